/* src/qdsc_axil.sv */
/*
 * AXI4-Lite slave for the four register words; only the control word is writable.
 * Assumes a single master on the same clock.
 */
`timescale 1ns/1ps
`include "qdsc_params.svh"

module qdsc_axil
	import qdsc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [3:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	output logic [31:0]      ctrl_r,
	input  wire logic [31:0] status_w,
	input  wire logic [31:0] outs_w,
	input  wire logic [31:0] regs_w
);

	logic        aw_r;
	logic        w_r;
	logic [3:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        wr_go;
	logic        wr_ok;
	logic        rd_ok;
	logic [31:0] rd_mux;

	assign s_awready = !aw_r && !s_bvalid;
	assign s_wready  = !w_r && !s_bvalid;
	assign s_arready = !s_rvalid;
	assign wr_go     = aw_r && w_r;
	assign wr_ok     = (awaddr_r == `QDSC_OFS_CTRL);
	assign rd_ok     = (s_araddr[1:0] == 2'h0);
	assign rd_mux    = (s_araddr == `QDSC_OFS_CTRL)   ? ctrl_r :
	                   (s_araddr == `QDSC_OFS_STATUS) ? status_w :
	                   (s_araddr == `QDSC_OFS_OUTS)   ? outs_w : regs_w;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r     <= 1'b0;
			w_r      <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_r     <= 1'b1;
				awaddr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_r     <= 1'b1;
				wdata_r <= s_wdata;
				wstrb_r <= s_wstrb;
			end
			if (wr_go) begin
				aw_r <= 1'b0;
				w_r  <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r   <= `QDSC_CTRL_RST;
			s_bvalid <= 1'b0;
			s_bresp  <= 2'h0;
		end else begin
			if (wr_go) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_ok ? 2'h0 : 2'h2;
				if (wr_ok && wstrb_r[0])
					ctrl_r[0] <= wdata_r[0];
			end else if (s_bready)
				s_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata  <= 32'h0000_0000;
			s_rresp  <= 2'h0;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
			s_rresp  <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_rready)
			s_rvalid <= 1'b0;
	end

endmodule

/* src/qdsc_params.svh */
/*
 * Constants of the quad DAC serial control block: frame layout,
 * mode and termination codes, register map, timing counts.
 * Assumes inclusion by bare name from package and modules.
 */
`ifndef QDSC_PARAMS_SVH
`define QDSC_PARAMS_SVH

// ---------------------------------------------------------------
// serial frame
// ---------------------------------------------------------------
`define QDSC_FRAME_BITS     5'd16
`define QDSC_ADDR_MSB       15
`define QDSC_ADDR_LSB       14
`define QDSC_MODE_MSB       13
`define QDSC_MODE_LSB       12
`define QDSC_CODE_MSB       11
`define QDSC_CODE_LSB       4

// ---------------------------------------------------------------
// mode and termination codes
// ---------------------------------------------------------------
`define QDSC_MODE_LOAD      2'h0
`define QDSC_MODE_LOAD_UPD  2'h1
`define QDSC_MODE_ALL_UPD   2'h2
`define QDSC_MODE_PWRDN     2'h3
`define QDSC_TERM_HIZ0      2'h0
`define QDSC_TERM_2K5       2'h1
`define QDSC_TERM_100K      2'h2
`define QDSC_TERM_HIZ3      2'h3

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define QDSC_OFS_CTRL       4'h0
`define QDSC_OFS_STATUS     4'h4
`define QDSC_OFS_OUTS       4'h8
`define QDSC_OFS_REGS       4'hC
`define QDSC_CTRL_RST       32'h0000_0000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define QDSC_CLK_MHZ        200
`define QDSC_WAKEUP_US      6
`define QDSC_WAKEUP_CYC     (`QDSC_WAKEUP_US * `QDSC_CLK_MHZ)

`endif

/* src/qdsc_pkg.sv */
/*
 * Types shared by the quad DAC serial control block.
 * Assumes qdsc_params.svh on the include path.
 */
`include "qdsc_params.svh"

package qdsc_pkg;

	typedef enum logic [1:0] {
		QDSC_IDLE  = 2'h0,
		QDSC_SHIFT = 2'h1,
		QDSC_DONE  = 2'h3
	} qdsc_state_e;

	typedef logic [7:0] qdsc_code_t;

endpackage

/* src/qdsc_sync.sv */
/*
 * Two-flop synchroniser for one level from outside aclk.
 * Assumes the input is asynchronous to aclk.
 */
`timescale 1ns/1ps

module qdsc_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic din,
	output logic      dout
);

	logic meta_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= RST_VAL;
			dout   <= RST_VAL;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end

endmodule

/* src/qdsc_top.sv */
/*
 * Quad 8-bit DAC serial control: three-wire write link, channel
 * registers, output update, power-down terminations, wake-up timer.
 * Assumes link pins asynchronous to aclk, sampled at 200 MHz.
 */
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
// How it works
// - frame opens on select low; data sampled on clock falls into 16 bits
// - sixteenth fall captures last bit and executes command; the code skips the command while control word bit 0 (hold) is set
// - after sixteenth fall, edges ignored until select rises
// - word order: two address, two mode, eight data, four ignored bits
// - address selects channel A to D
// - mode picks load, load+update, load all+update, power-down
// - msb first straight binary; zero gives 0V, ones full scale
// - ideal output is reference times code over 256
// - select rising before sixteenth fall discards the frame
// - reset clears registers; outputs zero until first valid update frame (mode 01 or 10)
// - mode 11 powers down all channels; address picks termination
// - termination: 00/11 high-z, 01 2.5k, 10 100k to ground
// - registers survive power-down unless reloaded by waking frame
// - wake-up measured from sixteenth fall of waking frame
`timescale 1ns/1ps
`include "qdsc_params.svh"

module qdsc_top
	import qdsc_pkg::*;
#(
	parameter int WAKEUP_CYC = `QDSC_WAKEUP_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        sync_n,
	input  wire logic        sclk,
	input  wire logic        sdin,
	input  wire logic [3:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [3:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	output logic [31:0]      analog_codes,
	output logic             powered_down,
	output logic [1:0]       out_termination,
	output logic             waking,
	output logic             frame_done
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic sync_n_s;
	logic sclk_s;
	logic sdin_s;

	// select idles high: reset to idle level, no false fall
	qdsc_sync #(.RST_VAL(1'b1)) u_sync_sel (.aclk(aclk), .aresetn(aresetn),
		.din(sync_n), .dout(sync_n_s));
	qdsc_sync u_sync_clk (.aclk(aclk), .aresetn(aresetn), .din(sclk), .dout(sclk_s));
	qdsc_sync u_sync_dat (.aclk(aclk), .aresetn(aresetn), .din(sdin), .dout(sdin_s));

	// ---------------------------------------------------------------
	// edge detection
	// ---------------------------------------------------------------
	logic sync_n_d_r;
	logic sclk_d_r;
	logic sdin_d_r;
	logic sclk_fall;
	logic sel_fall;

	assign sclk_fall = sclk_d_r && !sclk_s;
	assign sel_fall  = sync_n_d_r && !sync_n_s;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_n_d_r <= 1'b1;
			sclk_d_r   <= 1'b0;
			sdin_d_r   <= 1'b0;
		end else begin
			sync_n_d_r <= sync_n_s;
			sclk_d_r   <= sclk_s;
			sdin_d_r   <= sdin_s;
		end
	end

	// ---------------------------------------------------------------
	// frame state machine and shifter
	// ---------------------------------------------------------------
	qdsc_state_e state_r;
	qdsc_state_e state_nxt;
	logic [15:0] shift_r;
	logic [4:0]  cnt_r;
	logic        take_bit;
	logic        last_bit;
	logic [15:0] word_w;

	assign take_bit = (state_r == QDSC_SHIFT) && !sync_n_s && sclk_fall;
	assign last_bit = take_bit && (cnt_r == `QDSC_FRAME_BITS - 5'd1);
	assign word_w   = {shift_r[14:0], sdin_d_r};

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			QDSC_IDLE: begin
				if (sel_fall)
					state_nxt = QDSC_SHIFT;
			end
			QDSC_SHIFT: begin
				if (sync_n_s)
					state_nxt = QDSC_IDLE;
				else if (last_bit)
					state_nxt = QDSC_DONE;
			end
			QDSC_DONE: begin
				if (sync_n_s)
					state_nxt = QDSC_IDLE;
			end
			default: state_nxt = QDSC_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= QDSC_IDLE;
			shift_r <= 16'h0000;
			cnt_r   <= 5'h00;
		end else begin
			state_r <= state_nxt;
			if (state_r != QDSC_SHIFT)
				cnt_r <= 5'h00;
			else if (take_bit) begin
				shift_r <= word_w;
				cnt_r   <= cnt_r + 5'd1;
			end
		end
	end

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	logic [1:0] addr_w;
	logic [1:0] mode_w;
	qdsc_code_t code_w;
	logic       ctrl_hold;
	logic       exec;
	logic       upd_all;

	assign addr_w  = word_w[`QDSC_ADDR_MSB:`QDSC_ADDR_LSB];
	assign mode_w  = word_w[`QDSC_MODE_MSB:`QDSC_MODE_LSB];
	assign code_w  = word_w[`QDSC_CODE_MSB:`QDSC_CODE_LSB];
	assign exec    = last_bit && !ctrl_hold;
	assign upd_all = exec && (mode_w == `QDSC_MODE_LOAD_UPD || mode_w == `QDSC_MODE_ALL_UPD);

	// ---------------------------------------------------------------
	// channel registers and outputs
	// ---------------------------------------------------------------
	logic [7:0] dac_r [4];
	logic [7:0] out_r [4];
	logic [7:0] dac_nxt [4];

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_ch
			logic load_w;
			assign load_w = exec && ((mode_w == `QDSC_MODE_ALL_UPD) ||
			                ((mode_w != `QDSC_MODE_PWRDN) && (addr_w == 2'(gi))));
			assign dac_nxt[gi] = load_w ? code_w : dac_r[gi];
			assign analog_codes[gi*8 +: 8] = out_r[gi];

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					dac_r[gi] <= 8'h00;
					out_r[gi] <= 8'h00;
				end else begin
					dac_r[gi] <= dac_nxt[gi];
					if (upd_all)
						out_r[gi] <= dac_nxt[gi];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// power-down, wake-up timer, done pulse
	// ---------------------------------------------------------------
	logic [31:0] wake_cnt_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			powered_down    <= 1'b0;
			out_termination <= `QDSC_TERM_HIZ0;
			waking          <= 1'b0;
			wake_cnt_r      <= 32'h0000_0000;
			frame_done      <= 1'b0;
		end else begin
			frame_done <= exec;
			if (exec && mode_w == `QDSC_MODE_PWRDN) begin
				powered_down    <= 1'b1;
				out_termination <= addr_w;
				waking          <= 1'b0;
			end else if (exec && powered_down) begin
				powered_down <= 1'b0;
				waking       <= 1'b1;
				wake_cnt_r   <= 32'(WAKEUP_CYC);
			end else if (waking) begin
				wake_cnt_r <= wake_cnt_r - 32'd1;
				if (wake_cnt_r <= 32'd1)
					waking <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// register bus
	// ---------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic [31:0] status_w;
	logic [31:0] regs_w;

	assign ctrl_hold = ctrl_r[0];
	assign status_w  = {24'h000000, 1'b0, state_r, waking, out_termination,
	                    powered_down, ctrl_hold};
	assign regs_w    = {dac_r[3], dac_r[2], dac_r[1], dac_r[0]};

	qdsc_axil u_axil (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.ctrl_r    (ctrl_r),
		.status_w  (status_w),
		.outs_w    (analog_codes),
		.regs_w    (regs_w)
	);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	property p_abort;
		@(posedge aclk) disable iff (!aresetn)
		(state_r == QDSC_SHIFT && sync_n_s) |=> !frame_done;
	endproperty
	a_abort: assert property (p_abort) else $error("aborted frame executed");

	property p_ignore;
		@(posedge aclk) disable iff (!aresetn)
		(state_r == QDSC_DONE) |=> $stable(regs_w) && $stable(analog_codes);
	endproperty
	a_ignore: assert property (p_ignore) else $error("edge used after last bit");

	property p_count;
		@(posedge aclk) disable iff (!aresetn)
		frame_done |-> (state_r == QDSC_DONE) && (cnt_r == `QDSC_FRAME_BITS);
	endproperty
	a_count: assert property (p_count) else $error("frame not sixteen bits");

	property p_pd;
		@(posedge aclk) disable iff (!aresetn)
		(exec && mode_w == 2'h3) |=> powered_down && out_termination == $past(addr_w);
	endproperty
	a_pd: assert property (p_pd) else $error("power-down not applied");

	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
		(exec && mode_w == 2'h0) |=> $stable(analog_codes);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved without update");

	property p_keep;
		@(posedge aclk) disable iff (!aresetn)
		(exec && mode_w == 2'h3) |=> $stable(regs_w);
	endproperty
	a_keep: assert property (p_keep) else $error("register changed by power-down");

	property p_load;
		@(posedge aclk) disable iff (!aresetn)
		(exec && mode_w == 2'h1) |=> analog_codes[$past(addr_w)*8 +: 8] == $past(code_w);
	endproperty
	a_load: assert property (p_load) else $error("addressed channel not updated");

	property p_wake;
		@(posedge aclk) disable iff (!aresetn)
		(exec && powered_down && mode_w != 2'h3) |=> waking && !powered_down;
	endproperty
	a_wake: assert property (p_wake) else $error("wake-up not started");

	property p_zero;
		@(posedge aclk)
		!aresetn |=> analog_codes == 32'h0000_0000;
	endproperty
	a_zero: assert property (p_zero) else $error("outputs not zero after reset");

endmodule

/* tb/qdsc_host_model.sv */
/*
 * Host side of the three-wire write link: 16-bit frames, msb first.
 * Assumes the device samples data on falling clock edges.
 */
`timescale 1ns/1ps

module qdsc_host_model (
	output logic sync_n,
	output logic sclk,
	output logic sdin
);
	// ---------------------------------------------------------------
	// frame driver
	// ---------------------------------------------------------------
	// idle: clock still, data low
	initial begin
		sync_n = 1'b1;
		sclk   = 1'b1;
		sdin   = 1'b0;
	end

	// nfall below 16 aborts, above 16 adds extra edges
	task automatic frame(input logic [15:0] word, input int nfall);
		sync_n <= 1'b0;
		#40;
		// one bit per fall, msb first
		for (int i = 0; i < nfall; i++) begin
			sdin <= (i < 16) ? word[15 - i] : ~sdin;
			#32 sclk <= 1'b0;
			#32 sclk <= 1'b1;
		end
		#32 sync_n <= 1'b1;
		sdin <= 1'b0;
		#64;
	endtask
endmodule

/* tb/tb_top.sv */
/*
 * Bench for the quad DAC serial control: link frames from a host
 * model, register access over AXI4-Lite, self-checking.
 * Assumes design sources and qdsc_params.svh on the include path.
 */
`timescale 1ns/1ps
`include "qdsc_params.svh"

module tb_top;
	localparam int WK = 8;

	logic              aclk, aresetn, sync_n, sclk, sdin;
	logic [3:0]        s_awaddr, s_wstrb, s_araddr;
	logic              s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic              s_arvalid, s_arready, s_rvalid, s_rready;
	logic [31:0]       s_wdata, s_rdata, analog_codes;
	logic [1:0]        s_bresp, s_rresp, out_termination;
	logic              powered_down, waking, frame_done;
	logic [3:0][7:0]   reg_e, out_e;
	logic              pd_e, hold_e;
	logic [1:0]        term_e;
	int                failures, n_compared, n_done, n_wake;

	qdsc_top #(.WAKEUP_CYC(WK)) qdsc_top_inst (.aclk, .aresetn, .sync_n, .sclk, .sdin,
		.s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
		.s_rresp, .s_rvalid, .s_rready, .analog_codes, .powered_down, .out_termination,
		.waking, .frame_done);
	qdsc_host_model qdsc_host_model_inst (.sync_n, .sclk, .sdin);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (frame_done === 1'b1)
			n_done <= n_done + 1;
		if (waking === 1'b1)
			n_wake <= n_wake + 1;
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch t=%0t %s: got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		s_awaddr  <= a;
		s_awvalid <= 1'b1;
		s_wdata   <= d;
		s_wstrb   <= 4'hF;
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (s_awready === 1'b1)
				s_awvalid <= 1'b0;
			if (s_wready === 1'b1)
				s_wvalid <= 1'b0;
			if (s_bvalid === 1'b1) begin
				got = 1'b1;
				r = s_bresp;
				s_bready <= 1'b0;
			end
		end
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		while (!got) begin
			@(posedge aclk);
			if (s_arready === 1'b1)
				s_arvalid <= 1'b0;
			if (s_rvalid === 1'b1) begin
				got = 1'b1;
				d = s_rdata;
				r = s_rresp;
				s_rready <= 1'b0;
			end
		end
	endtask

	// one frame, then expected state updated and compared
	task automatic send(input logic [1:0] a, input logic [1:0] m, input logic [7:0] c,
		input int nf);
		int   d0, w0;
		logic run, woke;
		d0 = n_done;
		w0 = n_wake;
		run = (nf >= 16) && !hold_e;
		woke = run && pd_e && (m != `QDSC_MODE_PWRDN);
		qdsc_host_model_inst.frame({a, m, c, 4'hA}, nf);
		repeat (10) @(posedge aclk);
		if (run) begin
			case (m)
				`QDSC_MODE_LOAD: reg_e[a] = c;
				`QDSC_MODE_LOAD_UPD: begin
					reg_e[a] = c;
					out_e = reg_e;
				end
				`QDSC_MODE_ALL_UPD: begin
					reg_e = {4{c}};
					out_e = reg_e;
				end
				default: begin
					pd_e = 1'b1;
					term_e = a;
				end
			endcase
			if (woke)
				pd_e = 1'b0;
		end
		chk(analog_codes, out_e, "output codes");
		chk({31'h0, powered_down}, {31'h0, pd_e}, "power-down state");
		chk({30'h0, out_termination}, {30'h0, term_e}, "termination");
		chk(32'(n_done - d0), {31'h0, run}, "frame done pulses");
		chk(32'(n_wake - w0), 32'(woke ? WK : 0), "wake cycles");
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		chk(analog_codes, 32'h0, "codes after reset");
		chk({31'h0, powered_down}, 32'h0, "power after reset");
		$display("test reset done");
	endtask

	task automatic t_load();
		send(2'h1, `QDSC_MODE_LOAD, 8'h81, 16);
		send(2'h2, `QDSC_MODE_LOAD_UPD, 8'h3C, 16);
		send(2'h0, `QDSC_MODE_LOAD_UPD, 8'hFF, 16);
		send(2'h3, `QDSC_MODE_LOAD_UPD, 8'h01, 16);
		$display("test load done");
	endtask

	task automatic t_all();
		send(2'h2, `QDSC_MODE_ALL_UPD, 8'h5A, 16);
		$display("test load all done");
	endtask

	task automatic t_abort();
		send(2'h1, `QDSC_MODE_LOAD_UPD, 8'hC3, 15);
		send(2'h0, `QDSC_MODE_PWRDN, 8'h00, 8);
		send(2'h1, `QDSC_MODE_LOAD_UPD, 8'h96, 20);
		$display("test abort done");
	endtask

	task automatic t_pdown();
		for (int i = 0; i < 4; i++) begin
			send(2'(i), `QDSC_MODE_PWRDN, 8'hE7, 16);
			send(2'(i), i[0] ? `QDSC_MODE_LOAD_UPD : `QDSC_MODE_LOAD, 8'(8'h10 + i), 16);
		end
		$display("test power-down done");
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(`QDSC_OFS_CTRL, d, r);
		chk(d, `QDSC_CTRL_RST, "control reset value");
		axi_wr(`QDSC_OFS_STATUS, 32'h1, r);
		chk({30'h0, r}, 32'h2, "write to read-only word");
		axi_rd(4'h2, d, r);
		chk({d[29:0], r}, 32'h2, "unaligned read");
		axi_wr(`QDSC_OFS_CTRL, 32'h1, r);
		chk({30'h0, r}, 32'h0, "control write");
		hold_e = 1'b1;
		send(2'h3, `QDSC_MODE_LOAD_UPD, 8'h77, 16);
		axi_rd(`QDSC_OFS_STATUS, d, r);
		chk(d & 32'h7F, {28'h0, term_e, pd_e, 1'b1}, "status while held");
		axi_wr(`QDSC_OFS_CTRL, 32'h0, r);
		hold_e = 1'b0;
		axi_rd(`QDSC_OFS_OUTS, d, r);
		chk(d, out_e, "output codes word");
		axi_rd(`QDSC_OFS_REGS, d, r);
		chk(d, reg_e, "channel registers word");
		$display("test registers done");
	endtask

	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		{failures, n_compared, n_done, n_wake} = '0;
		{reg_e, out_e, pd_e, hold_e, term_e} = '0;
		aresetn = 1'b0;
		{s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
		{s_araddr, s_arvalid, s_rready} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (10) @(posedge aclk);
		t_reset();
		t_load();
		t_all();
		t_abort();
		t_pdown();
		t_regs();
		wrap_up();
	end

	initial begin
		#100000;
		failures++;
		$display("mismatch t=%0t watchdog expired", $time);
		wrap_up();
	end
endmodule
